// [verilog/rsr_pkg.sv]
// Purpose: shared constants and carriers for the radio serdes host registers
// Assumes: byte-wide register port, 8-bit addresses
// Notes: offsets are the register addresses seen by the host port
package rsr_pkg;
  localparam logic [7:0] RSR_ADDR_RX_IRQ_STAT = 8'h08;
  localparam logic [7:0] RSR_ADDR_A_BYTE = 8'h09;
  localparam logic [7:0] RSR_ADDR_A_MASK = 8'h0A;
  localparam logic [7:0] RSR_ADDR_B_BYTE = 8'h0B;
  localparam logic [7:0] RSR_ADDR_B_MASK = 8'h0C;
  localparam logic [7:0] RSR_ADDR_TX_IRQ_MASK = 8'h0D;
  localparam logic [7:0] RSR_ADDR_TX_IRQ_STAT = 8'h0E;
  // receive interrupt status bit positions
  localparam int RSR_BIT_A_FULL = 0;
  localparam int RSR_BIT_A_EOF = 1;
  localparam int RSR_BIT_A_ALL_GOOD = 3;
  // transmit enable / status bit positions
  localparam int RSR_BIT_TX_EMPTY = 0;
  localparam int RSR_BIT_TX_DONE = 1;
  localparam int RSR_BIT_TX_OVER = 2;
  localparam int RSR_BIT_TX_UNDER = 3;
  localparam logic [3:0] RSR_TX_MASK_BITS = 4'hF;
  localparam logic [7:0] RSR_RESET_BYTE = 8'h00;
  localparam logic [7:0] RSR_EOF_BITS_DEFAULT = 8'h03;

  // one received bit time from a channel receiver
  typedef struct packed {
    logic bit_tick;
    logic bit_good;
    logic bit_val;
  } rsr_rx_bit_t;

  // host register access strobes
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsr_host_req_t;

  // transmit status conditions from the transmitter
  typedef struct packed {
    logic under;
    logic over;
    logic done;
    logic empty;
  } rsr_tx_stat_t;
endpackage

// [verilog/rsr_regs.sv]
// Purpose: host-visible receive byte, mask and transmit enable registers
// Assumes: one clock, synchronous active-high reset, host strobes one cycle
// Notes: channel B status and transmit data registers live elsewhere
//
// Overview of operation
// - channel A end-of-frame set after configured idle bit times once started
// - reading receive interrupt status clears channel A end-of-frame flag
// - channel A full flag set when a complete byte moves to register
// - end of frame also moves partial byte and raises full
// - channel A byte read-only, bit 0 first received
// - channel A mask read-only, one marks matching bit valid
// - all-valid flag set means all eight A bits valid
// - channel B byte read-only, bit 0 first received
// - channel B mask read-only, one marks matching bit valid
// - enable bit 3 gates underflow interrupt
// - enable bit 2 gates overflow interrupt
// - enable bit 1 gates done interrupt
// - enable bit 0 gates empty interrupt
// - status bit 3 marks all A bits valid, never interrupts
module rsr_regs
  import rsr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host register port
  input rsr_pkg::rsr_host_req_t host_req,
  output logic [7:0] host_rdata,
  // end-of-frame idle bit count from serdes control
  input wire logic [7:0] eof_bits,
  // channel receivers
  input rsr_pkg::rsr_rx_bit_t rx_a,
  input rsr_pkg::rsr_rx_bit_t rx_b,
  // transmitter conditions
  input rsr_pkg::rsr_tx_stat_t tx_stat,
  // transmit interrupt
  output logic tx_irq
);
  import rsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] good;
    logic [3:0] count;
  } rsr_coll_t;

  // one received bit into a collector; a byte completes at eight bits
  function automatic rsr_coll_t rsr_push(rsr_coll_t c, rsr_rx_bit_t b);
    rsr_coll_t n;
    n = c;
    n.shift[c.count[2:0]] = b.bit_val;
    n.good[c.count[2:0]] = b.bit_good;
    n.count = c.count + 4'h1;
    return n;
  endfunction

  localparam rsr_coll_t RSR_COLL_EMPTY = '0;

  rsr_coll_t coll_a_q, coll_a_d, coll_b_q, coll_b_d;
  logic [7:0] a_byte_q, a_byte_d, a_mask_q, a_mask_d;
  logic [7:0] b_byte_q, b_byte_d, b_mask_q, b_mask_d;
  logic a_full_q, a_full_d, a_eof_q, a_eof_d, a_good_q, a_good_d;
  logic a_run_q, a_run_d;
  logic [7:0] a_idle_q, a_idle_d;
  logic [3:0] tx_en_q, tx_en_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rsr_coll_t na;
    rsr_coll_t nb;
    logic a_load;
    logic a_eof_ev;
    na = coll_a_q;
    nb = coll_b_q;
    a_load = 1'b0;
    a_eof_ev = 1'b0;
    coll_a_d = coll_a_q;
    coll_b_d = coll_b_q;
    a_byte_d = a_byte_q;
    a_mask_d = a_mask_q;
    b_byte_d = b_byte_q;
    b_mask_d = b_mask_q;
    a_run_d = a_run_q;
    a_idle_d = a_idle_q;
    a_good_d = a_good_q;
    // channel A: valid bits collect, idle bit times count to end of frame
    if (rx_a.bit_tick) begin
      if (rx_a.bit_good) begin
        na = rsr_push(coll_a_q, rx_a);
        a_run_d = 1'b1;
        a_idle_d = 8'h00;
        if (na.count == 4'h8) begin
          a_load = 1'b1;
        end
      end else if (a_run_q) begin
        a_idle_d = a_idle_q + 8'h01;
        // zero count already fires on the first idle bit time, as a count of one does
        if (a_idle_q + 8'h01 >= eof_bits || eof_bits == 8'h00) begin
          a_eof_ev = 1'b1;
          a_run_d = 1'b0;
          a_idle_d = 8'h00;
          a_load = (coll_a_q.count != 4'h0);
        end
      end
    end
    if (a_load) begin
      a_byte_d = na.shift;
      a_mask_d = na.good;
      a_good_d = (na.good == 8'hFF);
      coll_a_d = RSR_COLL_EMPTY;
    end else begin
      coll_a_d = na;
    end
    // channel B: complete bytes only; its status flags are held elsewhere
    if (rx_b.bit_tick && rx_b.bit_good) begin
      nb = rsr_push(coll_b_q, rx_b);
      if (nb.count == 4'h8) begin
        b_byte_d = nb.shift;
        b_mask_d = nb.good;
        coll_b_d = RSR_COLL_EMPTY;
      end else begin
        coll_b_d = nb;
      end
    end
    // set wins over the read-clear
    a_full_d = a_full_q;
    a_eof_d = a_eof_q;
    if (host_req.rd && host_req.addr == RSR_ADDR_RX_IRQ_STAT) begin
      a_full_d = 1'b0;
      a_eof_d = 1'b0;
    end
    if (a_load) begin
      a_full_d = 1'b1;
    end
    if (a_eof_ev) begin
      a_eof_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tx_en_d = tx_en_q;
    // reserved bits 7:4 are dropped; host is expected to write zeros
    if (host_req.wr && host_req.addr == RSR_ADDR_TX_IRQ_MASK) begin
      tx_en_d = host_req.wdata[3:0] & RSR_TX_MASK_BITS;
    end
    irq_d = (tx_en_q[RSR_BIT_TX_UNDER] & tx_stat.under)
          | (tx_en_q[RSR_BIT_TX_OVER] & tx_stat.over)
          | (tx_en_q[RSR_BIT_TX_DONE] & tx_stat.done)
          | (tx_en_q[RSR_BIT_TX_EMPTY] & tx_stat.empty);
    // all-valid flag feeds status only, never the interrupt
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_d = 8'h00;
    if (host_req.rd) begin
      unique case (host_req.addr)
        RSR_ADDR_RX_IRQ_STAT: begin
          rdata_d[RSR_BIT_A_FULL] = a_full_q;
          rdata_d[RSR_BIT_A_EOF] = a_eof_q;
          rdata_d[RSR_BIT_A_ALL_GOOD] = a_good_q;
        end
        RSR_ADDR_A_BYTE: rdata_d = a_byte_q;
        RSR_ADDR_A_MASK: rdata_d = a_mask_q;
        RSR_ADDR_B_BYTE: rdata_d = b_byte_q;
        RSR_ADDR_B_MASK: rdata_d = b_mask_q;
        RSR_ADDR_TX_IRQ_MASK: rdata_d = {4'h0, tx_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      coll_a_q <= RSR_COLL_EMPTY;
      coll_b_q <= RSR_COLL_EMPTY;
      a_byte_q <= RSR_RESET_BYTE;
      a_mask_q <= RSR_RESET_BYTE;
      b_byte_q <= RSR_RESET_BYTE;
      b_mask_q <= RSR_RESET_BYTE;
      a_full_q <= 1'b0;
      a_eof_q <= 1'b0;
      a_good_q <= 1'b0;
      a_run_q <= 1'b0;
      a_idle_q <= 8'h00;
      tx_en_q <= 4'h0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      coll_a_q <= coll_a_d;
      coll_b_q <= coll_b_d;
      a_byte_q <= a_byte_d;
      a_mask_q <= a_mask_d;
      b_byte_q <= b_byte_d;
      b_mask_q <= b_mask_d;
      a_full_q <= a_full_d;
      a_eof_q <= a_eof_d;
      a_good_q <= a_good_d;
      a_run_q <= a_run_d;
      a_idle_q <= a_idle_d;
      tx_en_q <= tx_en_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign host_rdata = rdata_q;
  assign tx_irq = irq_q;
endmodule

// [tb/rsr_regs_props.sv]
// Purpose: port checks for rsr_regs
// Assumes: one clock, rst synchronous active high
// Notes: enable register unseen, so irq is tied to its cause
module rsr_regs_props
  import rsr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input rsr_pkg::rsr_host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic [7:0] eof_bits,
  input rsr_pkg::rsr_rx_bit_t rx_a,
  input rsr_pkg::rsr_rx_bit_t rx_b,
  input rsr_pkg::rsr_tx_stat_t tx_stat,
  input wire logic tx_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // no channel A tick, so no flag can be set meanwhile
  sequence s_quiet;
    !rx_a.bit_tick;
  endsequence
  sequence s_rd(a);
    host_req.rd && host_req.addr == a && !rx_a.bit_tick;
  endsequence
  a_reset_zero: assert property (disable iff (1'b0)
    rst |=> host_rdata == 8'h00 && !tx_irq) else $error("reset output");
  a_irq_quiet: assert property (
    tx_stat == 4'h0 |=> !tx_irq) else $error("irq without cause");
  a_irq_cause: assert property (
    tx_irq |-> $past(tx_stat) != 4'h0) else $error("irq cause");
  a_idle_zero: assert property (
    !host_req.rd |=> host_rdata == 8'h00) else $error("idle rdata");
  a_unmapped_zero: assert property (
    s_rd(8'h00) |=> host_rdata == 8'h00) else $error("unmapped");
  a_mask_high: assert property (
    s_rd(8'h0D) |=> host_rdata[7:4] == 4'h0) else $error("mask high");
  a_stat_bits: assert property (
    s_rd(8'h08) |=> host_rdata[7:4] == 4'h0 && !host_rdata[2])
    else $error("status bits");
  a_eof_clear: assert property (
    s_rd(8'h08) ##1 s_quiet ##1 s_rd(8'h08) |=> host_rdata[1:0] == 2'b00)
    else $error("flags not cleared");
endmodule
bind rsr_regs rsr_regs_props i_props (.sys_clk(sys_clk), .rst(rst),
  .host_req(host_req), .host_rdata(host_rdata), .eof_bits(eof_bits),
  .rx_a(rx_a), .rx_b(rx_b), .tx_stat(tx_stat), .tx_irq(tx_irq));

// [tb/rsr_host_bfm.sv]
// Purpose: host side register access model
// Assumes: called from the bench, one access at a time
// Notes: released lines carry inverted values so stale data shows
module rsr_host_bfm
  import rsr_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output rsr_pkg::rsr_host_req_t host_req,
  input wire logic [7:0] host_rdata
);
  initial host_req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
  task automatic acc(input logic r, input logic [7:0] a, w,
                     output logic [7:0] d);
    @(posedge sys_clk);
    host_req <= '{r, !r, a, w};
    @(posedge sys_clk);
    host_req <= '{1'b0, 1'b0, ~a, ~w};
    #1 d = host_rdata;
  endtask
endmodule

// [tb/rsr_regs_tb.sv]
// Purpose: self-checking bench for rsr_regs
// Assumes: eof_bits fixed at 3, host accesses via rsr_host_bfm
// Notes: channel B only loads whole bytes here
module rsr_regs_tb;
  import rsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_irq;
  logic [7:0] host_rdata, d;
  rsr_host_req_t host_req;
  rsr_rx_bit_t rx_a = '0, rx_b = '0;
  rsr_tx_stat_t tx_stat = '0;
  int num_errors = 0, checked = 0, cycles = 0;
  initial forever #50 sys_clk = ~sys_clk;
  rsr_host_bfm i_host (.sys_clk(sys_clk), .host_req(host_req),
    .host_rdata(host_rdata));
  rsr_regs i_dut (.sys_clk(sys_clk), .rst(rst), .host_req(host_req),
    .host_rdata(host_rdata), .eof_bits(8'h03), .rx_a(rx_a), .rx_b(rx_b),
    .tx_stat(tx_stat), .tx_irq(tx_irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    i_host.acc(1'b1, a, 8'h00, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  // one tick per two cycles, lsb first
  task automatic bits(input logic [7:0] a, b, input int n, input logic g);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_a <= '{1'b1, g, a[i]};
      rx_b <= '{1'b1, g, b[i]};
      @(posedge sys_clk);
      rx_a <= '0;
      rx_b <= '0;
    end
    repeat (3) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 15; a++) rc(8'(a), 8'h00);
  endtask
  task automatic t_full();
    bits(8'hA5, 8'h3C, 8, 1'b1);
    rc(8'h09, 8'hA5);
    rc(8'h0A, 8'hFF);
    rc(8'h0B, 8'h3C);
    rc(8'h0C, 8'hFF);
    rc(8'h08, 8'h09);
    i_host.acc(1'b1, 8'h08, 8'h00, d);
    chk("flags", d & 8'h03, 8'h00);
  endtask
  task automatic t_eof();
    bits(8'h05, 8'h00, 3, 1'b1);
    bits(8'h00, 8'h00, 3, 1'b0);
    i_host.acc(1'b0, 8'h09, 8'hFF, d);
    rc(8'h09, 8'h05);
    rc(8'h0A, 8'h07);
    rc(8'h08, 8'h03);
  endtask
  task automatic t_irq();
    i_host.acc(1'b0, 8'h0D, 8'h05, d);
    rc(8'h0D, 8'h05);
    for (int i = 0; i < 4; i++) begin
      i_host.acc(1'b0, 8'h0D, 8'h01 << i, d);
      @(posedge sys_clk) tx_stat <= 4'h1 << i;
      repeat (3) @(posedge sys_clk);
      #1 chk("irq", {7'h00, tx_irq}, 8'h01);
      @(posedge sys_clk) tx_stat <= ~(4'h1 << i);
      repeat (3) @(posedge sys_clk);
      #1 chk("masked", {7'h00, tx_irq}, 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_full();
    t_eof();
    t_irq();
    end_sim();
  end
endmodule
